// ### logic/clock_sync_serial_io.sv
module clock_sync_serial_io (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic serial_in_pin_i,
  input wire logic transfer_clock_pin_i,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe_n_o,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  clock_sync_serial_pkg::ctrl_t ctrl_reg;
  logic [7:0] divider_reg;
  logic [7:0] shift_reg;
  logic status_done_reg;
  logic mask_reg;
  logic [5:0] port_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  clock_sync_serial_pkg::xfer_state_t state_reg;
  clock_sync_serial_pkg::xfer_state_t state_next;
  logic [clock_sync_serial_pkg::PRESCALE_W-1:0] prescale_reg;
  logic [7:0] rate_cnt_reg;
  logic sclk_reg;
  logic [2:0] bit_cnt_reg;
  logic sout_reg;
  logic sout_drive_reg;
  logic ext_clk_q_reg;
  clock_sync_serial_pkg::pin_drive_t clk_pin_reg;
  clock_sync_serial_pkg::pin_drive_t sout_pin_reg;
  clock_sync_serial_pkg::pin_drive_t clk_pin_next;
  clock_sync_serial_pkg::pin_drive_t sout_pin_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire bus_req = cyc_i && stb_i && !ack_reg;
  wire bus_wr = bus_req && we_i && sel_i[0];
  wire wr_ctrl = bus_wr && (adr_i == clock_sync_serial_pkg::CTRL_OFFSET);
  wire wr_divider = bus_wr && (adr_i == clock_sync_serial_pkg::DIVIDER_OFFSET);
  wire wr_shift = bus_wr && (adr_i == clock_sync_serial_pkg::SHIFT_OFFSET);
  wire wr_status = bus_wr && (adr_i == clock_sync_serial_pkg::STATUS_OFFSET);
  wire wr_mask = bus_wr && (adr_i == clock_sync_serial_pkg::MASK_OFFSET);
  wire wr_port = bus_wr && (adr_i == clock_sync_serial_pkg::PORT_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer clock generation and edge classification.

  wire internal_clk = ctrl_reg.clock_source_select;
  wire pol = ctrl_reg.clock_polarity_select;
  wire idle_level = !pol;
  wire busy = (state_reg == clock_sync_serial_pkg::ST_SHIFT);

  logic src_tick;
  always_comb begin
    case (ctrl_reg.count_source)
      clock_sync_serial_pkg::SRC_DIV1: src_tick = 1'b1;
      clock_sync_serial_pkg::SRC_DIV2: src_tick = &prescale_reg[0:0];
      clock_sync_serial_pkg::SRC_DIV8: src_tick = &prescale_reg[2:0];
      clock_sync_serial_pkg::SRC_DIV32: src_tick = &prescale_reg;
      default: src_tick = 1'b0;
    endcase
  end

  // A half period is n+1 ticks of the count source, so a full period is 2(n+1).
  wire half_done = src_tick && (rate_cnt_reg == divider_reg);
  wire int_toggle = internal_clk && (state_reg != clock_sync_serial_pkg::ST_IDLE) && half_done;
  wire int_edge = int_toggle && busy;
  wire int_new_level = !sclk_reg;

  // The pin is taken as synchronous; one register marks its last level.
  wire ext_edge = !internal_clk && ctrl_reg.serial_enable &&
                  (transfer_clock_pin_i != ext_clk_q_reg);

  wire any_edge = int_edge || ext_edge;
  wire new_level = internal_clk ? int_new_level : transfer_clock_pin_i;
  // Leading edge leaves the idle level and drives data; trailing samples.
  wire leading_edge = any_edge && (new_level == pol);
  wire trailing_edge = any_edge && (new_level != pol);
  wire last_bit = (bit_cnt_reg == clock_sync_serial_pkg::BIT_CNT_LAST);
  wire xfer_done = trailing_edge && last_bit && busy;

  function automatic logic [7:0] shift_in(input logic [7:0] data, input logic bit_in,
                                          input logic msb_first);
    shift_in = msb_first ? {data[6:0], bit_in} : {bit_in, data[7:1]};
  endfunction : shift_in

  wire out_bit = ctrl_reg.msb_first ? shift_reg[7] : shift_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing.

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      clock_sync_serial_pkg::ST_IDLE: begin
        if (wr_shift && ctrl_reg.serial_enable) begin
          state_next = clock_sync_serial_pkg::ST_SHIFT;
        end
      end
      clock_sync_serial_pkg::ST_SHIFT: begin
        if (!ctrl_reg.serial_enable) begin
          state_next = clock_sync_serial_pkg::ST_IDLE;
        end else if (wr_shift) begin
          state_next = clock_sync_serial_pkg::ST_SHIFT;
        end else if (xfer_done) begin
          state_next = internal_clk ? clock_sync_serial_pkg::ST_HOLD
                                    : clock_sync_serial_pkg::ST_IDLE;
        end
      end
      clock_sync_serial_pkg::ST_HOLD: begin
        if (wr_shift) begin
          state_next = clock_sync_serial_pkg::ST_SHIFT;
        end else if (half_done || !ctrl_reg.serial_enable) begin
          state_next = clock_sync_serial_pkg::ST_IDLE;
        end
      end
      default: state_next = clock_sync_serial_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= clock_sync_serial_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_shift || state_reg == clock_sync_serial_pkg::ST_IDLE) begin
      rate_cnt_reg <= 8'h00;
    end else if (half_done) begin
      rate_cnt_reg <= 8'h00;
    end else if (src_tick) begin
      rate_cnt_reg <= rate_cnt_reg + 8'h01;
    end
  end

  // The internal clock only toggles while shifting, so it rests at idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_reg <= 1'b1;
    end else if (!busy || wr_shift) begin
      sclk_reg <= idle_level;
    end else if (int_edge) begin
      sclk_reg <= int_new_level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_clk_q_reg <= 1'b0;
    end else begin
      ext_clk_q_reg <= transfer_clock_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_shift) begin
      bit_cnt_reg <= 3'h0;
    end else if (trailing_edge) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg <= clock_sync_serial_pkg::SHIFT_RESET;
    end else if (wr_shift) begin
      shift_reg <= dat_i[7:0];
    end else if (trailing_edge) begin
      // An external clock keeps shifting as long as pulses arrive.
      shift_reg <= shift_in(shift_reg, serial_in_pin_i, ctrl_reg.msb_first);
    end
  end

  // The output bit persists between bytes, keeping the last bit sent, until a control write with bit 6 clear loads bit 7.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sout_reg <= 1'b0;
    end else if (leading_edge) begin
      sout_reg <= out_bit;
    end else if (wr_ctrl && !busy && !dat_i[6]) begin
      sout_reg <= dat_i[7];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_shift || state_next == clock_sync_serial_pkg::ST_IDLE) begin
      sout_drive_reg <= 1'b0;
    end else if (leading_edge) begin
      sout_drive_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin roles.

  always_comb begin
    if (!ctrl_reg.serial_enable) begin
      clk_pin_next.level = port_reg[clock_sync_serial_pkg::PORT_CLK_BIT];
      clk_pin_next.oe_n = !port_reg[clock_sync_serial_pkg::PORT_CLK_DRIVE_BIT];
      sout_pin_next.level = port_reg[clock_sync_serial_pkg::PORT_SOUT_BIT];
      sout_pin_next.oe_n = !port_reg[clock_sync_serial_pkg::PORT_SOUT_DRIVE_BIT];
    end else if (internal_clk) begin
      clk_pin_next.level = sclk_reg;
      clk_pin_next.oe_n = 1'b0;
      sout_pin_next.level = sout_reg;
      sout_pin_next.oe_n = !sout_drive_reg;
    end else begin
      clk_pin_next.level = 1'b0;
      clk_pin_next.oe_n = 1'b1;
      sout_pin_next.level = sout_reg;
      sout_pin_next.oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_pin_reg <= '{level: 1'b0, oe_n: 1'b1};
      sout_pin_reg <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      clk_pin_reg <= clk_pin_next;
      sout_pin_reg <= sout_pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= clock_sync_serial_pkg::CTRL_RESET;
      divider_reg <= clock_sync_serial_pkg::DIVIDER_RESET;
      mask_reg <= 1'b0;
      port_reg <= clock_sync_serial_pkg::PORT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= dat_i[7:0];
      end
      if (wr_divider) begin
        divider_reg <= dat_i[7:0];
      end
      if (wr_mask) begin
        mask_reg <= dat_i[clock_sync_serial_pkg::STATUS_DONE_BIT];
      end
      if (wr_port) begin
        port_reg <= dat_i[5:0];
      end
    end
  end

  // A completion in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_done_reg <= 1'b0;
    end else if (xfer_done) begin
      status_done_reg <= 1'b1;
    end else if (wr_status && dat_i[clock_sync_serial_pkg::STATUS_DONE_BIT]) begin
      status_done_reg <= 1'b0;
    end
  end

  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (adr_i)
      clock_sync_serial_pkg::CTRL_OFFSET: rdata_next[7:0] = ctrl_reg;
      clock_sync_serial_pkg::DIVIDER_OFFSET: rdata_next[7:0] = divider_reg;
      clock_sync_serial_pkg::SHIFT_OFFSET: rdata_next[7:0] = shift_reg;
      clock_sync_serial_pkg::STATUS_OFFSET: begin
        rdata_next[clock_sync_serial_pkg::STATUS_DONE_BIT] = status_done_reg;
        rdata_next[clock_sync_serial_pkg::STATUS_BUSY_BIT] = busy;
      end
      clock_sync_serial_pkg::MASK_OFFSET: rdata_next[0] = mask_reg;
      clock_sync_serial_pkg::PORT_OFFSET: begin
        rdata_next[5:0] = port_reg;
        rdata_next[clock_sync_serial_pkg::PORT_SIN_IN_BIT] = serial_in_pin_i;
        rdata_next[clock_sync_serial_pkg::PORT_CLK_IN_BIT] = transfer_clock_pin_i;
        rdata_next[clock_sync_serial_pkg::PORT_SOUT_IN_BIT] = serial_out_pin_i;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
      rdata_reg <= bus_req ? rdata_next : 32'h0000_0000;
      irq_reg <= (status_done_reg || xfer_done) && mask_reg;
    end
  end

  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;
  assign irq_o = irq_reg;
  assign transfer_clock_pin_o = clk_pin_reg.level;
  assign transfer_clock_pin_oe_n_o = clk_pin_reg.oe_n;
  assign serial_out_pin_o = sout_pin_reg.level;
  assign serial_out_pin_oe_n_o = sout_pin_reg.oe_n;

endmodule : clock_sync_serial_io

// ### include/clock_sync_serial_pkg.sv
package clock_sync_serial_pkg;

  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned PRESCALE_W = 5;

  // Register byte addresses on the bus.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] DIVIDER_OFFSET = 8'h04;
  localparam logic [7:0] SHIFT_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] MASK_OFFSET = 8'h10;
  localparam logic [7:0] PORT_OFFSET = 8'h14;

  // Field positions outside the control byte.
  localparam int unsigned STATUS_DONE_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 8;
  localparam int unsigned PORT_SOUT_BIT = 0;
  localparam int unsigned PORT_CLK_BIT = 1;
  localparam int unsigned PORT_SOUT_DRIVE_BIT = 4;
  localparam int unsigned PORT_CLK_DRIVE_BIT = 5;
  localparam int unsigned PORT_SIN_IN_BIT = 8;
  localparam int unsigned PORT_CLK_IN_BIT = 9;
  localparam int unsigned PORT_SOUT_IN_BIT = 10;

  // Count source selection codes.
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV8 = 2'h2;
  localparam logic [1:0] SRC_DIV32 = 2'h3;

  // Values after reset, and the bit count of the last bit.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [5:0] PORT_RESET = 6'h00;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  typedef struct packed {
    logic output_level_control_bit;
    logic clock_source_select;
    logic serial_enable;
    logic reserved;
    logic msb_first;
    logic clock_polarity_select;
    logic [1:0] count_source;
  } ctrl_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_HOLD = 2'b11
  } xfer_state_t;

endpackage : clock_sync_serial_pkg

// ### tb/clock_sync_serial_io_sva.sv
module clock_sync_serial_io_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic transfer_clock_pin_o,
  input wire logic transfer_clock_pin_oe_n_o,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_n_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic clk_q_reg;
  logic [4:0] edge_cnt_reg;
  // Counts clock pin edges that the block drives since the last register write.
  always_ff @(posedge clk_i) begin
    clk_q_reg <= transfer_clock_pin_o;
    if (rst_i || (ack_o && we_i)) begin
      edge_cnt_reg <= 5'h00;
    end else if (!transfer_clock_pin_oe_n_o && clk_q_reg != transfer_clock_pin_o) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end
  ////////////////////////////////////////
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_follow: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered after one cycle");
  chk_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data seen outside the ack cycle");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o
    && serial_out_pin_oe_n_o && transfer_clock_pin_oe_n_o)
    else $error("outputs not quiet after reset");
  chk_sout_align: assert property (
    !transfer_clock_pin_oe_n_o && !serial_out_pin_oe_n_o && $past(!serial_out_pin_oe_n_o)
    && $changed(serial_out_pin_o) |-> $changed(transfer_clock_pin_o))
    else $error("output bit moved away from a clock edge");
  chk_irq_fall: assert property ($fell(irq_o) |-> ack_o || $past(ack_o))
    else $error("interrupt dropped without a register write");
  chk_pulse_limit: assert property (edge_cnt_reg <= 5'h10)
    else $error("more than eight clock pulses in one transfer");
  chk_done_edge: assert property (
    $rose(irq_o) && edge_cnt_reg != 5'h00 |-> edge_cnt_reg >= 5'h0F)
    else $error("interrupt raised before the last clock pulse");
  cov_irq: cover property ($rose(irq_o));
  cov_frame: cover property (edge_cnt_reg == 5'h10);
  cov_write: cover property (ack_o && we_i);
endmodule : clock_sync_serial_io_sva

bind clock_sync_serial_io clock_sync_serial_io_sva sva_chk (.clk_i, .rst_i, .we_i, .cyc_i,
  .stb_i, .dat_o, .ack_o, .transfer_clock_pin_o, .transfer_clock_pin_oe_n_o,
  .serial_out_pin_o, .serial_out_pin_oe_n_o, .irq_o);

// ### tb/serial_peer_model.sv
module serial_peer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sout_i,
  input wire logic pol_i,
  input wire logic msb_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  input wire logic ext_i,
  input wire logic go_i,
  output logic sin_o = 1'b0,
  output logic sclk_o = 1'b1,
  output logic [7:0] rx_o,
  output int period_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;
  logic [7:0] txb;
  int idx;
  int since;
  int gen;
  always @(posedge clk_i) begin
    prev <= sclk_i;
    since <= since + 1;
    if (rst_i || load_i) begin
      idx <= 0;
      txb <= tx_i;
      sin_o <= 1'b0;
    end else if (prev != sclk_i && sclk_i == pol_i) begin
      sin_o <= msb_i ? txb[7 - idx] : txb[idx];
      period_o <= since;
      since <= 1;
    end else if (prev != sclk_i) begin
      rx_o <= msb_i ? {rx_o[6:0], sout_i} : {sout_i, rx_o[7:1]};
      idx <= idx + 1;
    end else if (idx > 7) begin
      // A released data line must never look like a held bit.
      sin_o <= ~sin_o;
    end
  end
  // Peer clock: eight pulses of eight cycles, parked at the idle level outside frames.
  always @(posedge clk_i) begin
    if (rst_i || !ext_i) begin
      gen <= 0;
      sclk_o <= ~pol_i;
    end else if (go_i) begin
      gen <= 64;
    end else if (gen > 0) begin
      gen <= gen - 1;
      if (gen % 4 == 1) begin
        sclk_o <= ~sclk_o;
      end
    end
  end
endmodule : serial_peer_model

// ### tb/clock_sync_serial_io_tb_top.sv
module clock_sync_serial_io_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] R_CTRL = clock_sync_serial_pkg::CTRL_OFFSET;
  localparam logic [7:0] R_DIV = clock_sync_serial_pkg::DIVIDER_OFFSET;
  localparam logic [7:0] R_SHIFT = clock_sync_serial_pkg::SHIFT_OFFSET;
  localparam logic [7:0] R_STAT = clock_sync_serial_pkg::STATUS_OFFSET;
  localparam logic [7:0] R_MASK = clock_sync_serial_pkg::MASK_OFFSET;
  localparam logic [7:0] R_PORT = clock_sync_serial_pkg::PORT_OFFSET;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic pol = 1'b0, msb = 1'b0, ext = 1'b0, load = 1'b0, go = 1'b0;
  logic sclk_q = 1'b0, sout_q = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, sclk_o, sclk_oe_n, sout_o, sout_oe_n, irq_o, sin, peer_sclk;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx;
  int period;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  wire logic sclk_w = !sclk_oe_n ? sclk_o : (ext ? peer_sclk : ~sclk_q);
  wire logic sout_w = !sout_oe_n ? sout_o : ~sout_q;
  clock_sync_serial_io dut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i,
    .dat_o, .ack_o, .serial_in_pin_i(sin), .transfer_clock_pin_i(sclk_w),
    .transfer_clock_pin_o(sclk_o), .transfer_clock_pin_oe_n_o(sclk_oe_n),
    .serial_out_pin_i(sout_w), .serial_out_pin_o(sout_o), .serial_out_pin_oe_n_o(sout_oe_n),
    .irq_o);
  serial_peer_model peer (.clk_i, .rst_i, .sclk_i(sclk_w), .sout_i(sout_w), .pol_i(pol),
    .msb_i(msb), .load_i(load), .tx_i(tx), .ext_i(ext), .go_i(go), .sin_o(sin),
    .sclk_o(peer_sclk), .rx_o(rx), .period_o(period));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    sclk_q <= sclk_w;
    sout_q <= sout_w;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_total++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, 4'hF, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, 4'hF, q);
    chk(nm, e, q);
  endtask : rd
  task automatic arm(input logic [7:0] b);
    @(posedge clk_i);
    tx <= ~b;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
  endtask : arm
  initial begin
    int divs[4] = '{1, 2, 8, 32};
    int h;
    logic [7:0] b;
    logic [31:0] junk;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(R_CTRL, 32'h0, "ctrl reset");
    rd(R_STAT, 32'h0, "status reset");
    rd(R_MASK, 32'h0, "mask reset");
    // Port mode drives both pins from the port register; the data input pin is masked.
    wr(R_PORT, 32'h33);
    wb(R_PORT, 1'b0, 32'h0, 4'hF, junk);
    chk("port high", 32'h0000_0633, junk & 32'hFFFF_FEFF);
    wr(R_PORT, 32'h30);
    wb(R_PORT, 1'b0, 32'h0, 4'hF, junk);
    chk("port low", 32'h0000_0030, junk & 32'hFFFF_FEFF);
    wr(8'h18, 32'hFF);
    rd(8'h18, 32'h0, "unmapped");
    wr(R_DIV, 32'h5A);
    wb(R_DIV, 1'b1, 32'hFF, 4'h2, junk);
    rd(R_DIV, 32'h5A, "divider");
    wr(R_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      h = 3 * divs[i];
      b = 8'h96 ^ i[7:0];
      pol <= !i[1];
      msb <= i[0];
      wr(R_DIV, 32'h2);
      wr(R_CTRL, {24'h0, 4'h6, i[0], !i[1], i[1:0]});
      arm(b);
      wr(R_SHIFT, {24'h0, b});
      rd(R_STAT, 32'h100, "busy");
      while (irq_o !== 1'b1) @(negedge clk_i);
      chk("sout held", 1'b0, sout_oe_n);
      if (i == 3) begin
        // A write inside the hold interval must float the output at once.
        arm(b);
        wr(R_SHIFT, {24'h0, b});
        @(negedge clk_i);
        chk("sout float on write", 1'b1, sout_oe_n);
        wr(R_STAT, 32'h1);
        @(negedge clk_i);
        while (irq_o !== 1'b1) @(negedge clk_i);
      end
      repeat (2 * h + 2) @(negedge clk_i);
      chk("sout float", 1'b1, sout_oe_n);
      chk("idle clock", !pol, sclk_w);
      chk("period", 2 * h, period);
      chk("peer byte", b, rx);
      rd(R_SHIFT, {24'h0, ~b}, "received");
      if (i == 0) begin
        wr(R_MASK, 32'h0);
        @(negedge clk_i);
        chk("irq masked", 1'b0, irq_o);
        wr(R_MASK, 32'h1);
        @(negedge clk_i);
        chk("irq unmasked", 1'b1, irq_o);
      end
      rd(R_STAT, 32'h1, "done");
      wr(R_STAT, 32'h1);
      rd(R_STAT, 32'h0, "done cleared");
      @(negedge clk_i);
      chk("irq cleared", 1'b0, irq_o);
    end
    @(posedge clk_i);
    ext <= 1'b1;
    pol <= 1'b0;
    msb <= 1'b1;
    wr(R_CTRL, 32'h28);
    @(negedge clk_i);
    chk("level low", 1'b0, sout_o);
    wr(R_CTRL, 32'hA8);
    @(negedge clk_i);
    chk("level high", 1'b1, sout_o);
    for (int j = 0; j < 2; j++) begin
      b = j ? 8'hC2 : 8'h3C;
      arm(b);
      wr(R_SHIFT, {24'h0, b});
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (72) @(negedge clk_i);
      chk("last bit kept", 1'b0, sout_o);
      chk("peer byte ext", b, rx);
      rd(R_SHIFT, {24'h0, ~b}, "received ext");
      rd(R_STAT, 32'h1, "done ext");
      wr(R_STAT, 32'h1);
    end
    // A second reset in mid-run must bring the control and divider registers back to zero.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(R_CTRL, 32'h0, "ctrl after reset");
    rd(R_DIV, 32'h0, "divider after reset");
    close_out();
  end
endmodule : clock_sync_serial_io_tb_top
